// ### rtl/spc_pkg.sv
// Operation
// [RL1] Control bit 7 lets the transmit-empty request out; with it clear the request stays low.
// [RL2] The transmit-empty request drops when the empty flag is read as one then written to zero, or its enable is cleared.
// [RL3] Control bit 6 gates both the receive-full and the receive-error requests.
// [RL4] Those requests drop when a receive flag is read as one then cleared, or the receive enable is cleared; here clearing bit 6 drops them, bit 4 does not.
// [RL5] With transmit enable (bit 5) set, a frame goes out once the buffer is written and the empty flag cleared; here only in asynchronous mode.
// [RL6] Software sets the frame format in the mode register before enabling transmit or receive.
// [RL7] While transmit is disabled the transmit-empty flag reads one.
// [RL8] With receive enable (bit 4) set, reception starts on a start bit, or on the serial clock in synchronous mode.
// [RL9] Clearing receive enable leaves the receive-full and error flags as they were.
// [RL10] With address wake (bit 3) on in multiprocessor format, frames with a zero address bit set no flags.
// [RL11] Such skipped frames are not copied to the receive buffer and are not checked for errors.
// [RL12] A frame with the address bit one sets the received address bit and clears address wake by hardware.
// [RL13] The normal meanings of the control bits hold only while the card mode select bit is zero; here bit 5 clear still holds the empty flag at one.
// [RL14] Control bit 2 gates the transmit-end request.
// [RL15] Clock select bits 1..0: 00 internal, 01 internal with bit clock out, 1x external clock at 16x.
package spc_pkg;
    localparam logic [7:0] SPC_OFS_CTRL = 8'h00;
    localparam logic [7:0] SPC_OFS_STAT = 8'h04;
    localparam logic [7:0] SPC_OFS_TXBUF = 8'h08;
    localparam logic [7:0] SPC_OFS_RXBUF = 8'h0c;
    localparam logic [7:0] SPC_OFS_MODE = 8'h10;
    localparam logic [7:0] SPC_OFS_CARD = 8'h14;
    localparam logic [7:0] SPC_OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] SPC_OFS_IRQ_MASK = 8'h1c;
    localparam logic [7:0] SPC_CTRL_RST = 8'h00;
    localparam logic [7:0] SPC_STAT_RST = 8'h84;
    localparam logic [7:0] SPC_MODE_RST = 8'h00;
    localparam int SPC_MODE_PAR_EN = 0;
    localparam int SPC_MODE_PAR_ODD = 1;
    localparam int SPC_MODE_MP = 2;
    localparam int SPC_MODE_SYNC = 3;
    localparam int SPC_CARD_SEL = 0;
    localparam logic [7:0] SPC_STAT_CLR_MASK = 8'hf8;
    localparam int SPC_IRQ_TXE = 0;
    localparam int SPC_IRQ_TEND = 1;
    localparam int SPC_IRQ_RX = 2;
    localparam int SPC_IRQ_ERR = 3;
    localparam logic [1:0] SPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;
    localparam int SPC_CLK_HZ = 200000000;
    localparam int SPC_BIT_RATE = 115200;
    localparam int SPC_OVERSAMPLE = 16;
    localparam int SPC_TICK_DIV = SPC_CLK_HZ / (SPC_BIT_RATE * SPC_OVERSAMPLE);
    localparam logic [3:0] SPC_PH_LAST = 4'hf;
    localparam logic [3:0] SPC_PH_MID = 4'h7;
    localparam logic [3:0] SPC_SYNC_BITS = 4'h8;

    typedef struct packed {
        logic tx_empty_irq_en;
        logic rx_full_irq_en;
        logic tx_on_bit;
        logic rx_on_bit;
        logic addr_wake_en;
        logic tx_done_irq_en;
        logic clk_src_sel_hi;
        logic clk_src_sel_lo;
    } spc_ctrl_s;

    typedef struct packed {
        logic tx_buf_empty_flag;
        logic rx_buf_full_flag;
        logic overrun_err_flag;
        logic framing_err_flag;
        logic parity_err_flag;
        logic tx_end_flag;
        logic addr_bit_rx;
        logic addr_bit_tx;
    } spc_stat_s;

    typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} spc_tx_e;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_SYNC = 2'b11
    } spc_rx_e;
endpackage

// ### rtl/spc_serial_port_control.sv
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module spc_serial_port_control
    import spc_pkg::*;
#(
    parameter int TICK_DIV = SPC_TICK_DIV
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial line
    input wire logic rxd,
    output logic txd,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    // Interrupt requests
    output logic tx_empty_irq,
    output logic rx_full_irq,
    output logic rx_error_irq,
    output logic tx_done_irq,
    output logic irq
);
    spc_ctrl_s ctrl_q;
    spc_stat_s stat_q, seen_q;
    logic [7:0] mode_q, card_q, tx_buf_q, rx_buf_q;
    logic [3:0] irq_stat_q, irq_mask_q, irq_ev;
    logic aw_have_q, w_have_q;
    logic [7:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_strb_q;
    logic wr_fire, st_wr, normal, sync_md, mp_md;
    logic rxd_s1, rxd_s2, sck_s1, sck_s2, sck_s3, sck_rise;
    logic [15:0] div_q;
    logic tick_int, tick16;
    logic [3:0] sck_cnt_q;
    spc_tx_e tx_st_q;
    logic [10:0] tx_frame_q;
    logic [3:0] tx_bits_q, tx_ph_q;
    logic tx_start, tx_end, tx_xb_en, tx_xb;
    spc_rx_e rx_st_q;
    logic [10:0] rx_sh_q, rx_w;
    logic [3:0] rx_ph_q, rx_cnt_q, rx_nbits;
    logic rx_fin, rx_xb, rx_skip, rx_acc, rx_stop_ok, rx_perr;
    logic [7:0] rx_data, clr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a[7:2] == ofs[7:2];
    endfunction

    assign normal = !card_q[SPC_CARD_SEL]; // see [RL13]
    assign sync_md = mode_q[SPC_MODE_SYNC];
    assign mp_md = mode_q[SPC_MODE_MP] && !sync_md;

    // Pin synchronisers; third stage only feeds the edge detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {rxd_s1, rxd_s2} <= 2'b11;
            {sck_s1, sck_s2, sck_s3} <= 3'b000;
        end else begin
            rxd_s1 <= rxd;
            rxd_s2 <= rxd_s1;
            sck_s1 <= sck_i;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
        end
    end
    assign sck_rise = sck_s2 && !sck_s3;

    // Oversample tick: internal divider or external 16x clock
    always_ff @(posedge aclk) begin
        if (!aresetn || tick_int) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end
    assign tick_int = div_q == 16'(TICK_DIV - 1);
    assign tick16 = ctrl_q.clk_src_sel_hi ? sck_rise : tick_int; // see [RL15]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_cnt_q <= 4'h0;
        end else if (tick16) begin
            sck_cnt_q <= sck_cnt_q + 4'h1;
        end
    end
    assign sck_o = sck_cnt_q[3];
    // Bit-rate clock is driven only in asynchronous mode with select 01
    assign sck_oe = normal && !sync_md && ({ctrl_q.clk_src_sel_hi, ctrl_q.clk_src_sel_lo} == 2'b01); // see [RL15]

    // AXI4-Lite write channel: address and data taken in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign st_wr = wr_fire && w_strb_q && hit(aw_addr_q, SPC_OFS_STAT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SPC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_strb_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q > SPC_OFS_IRQ_MASK + 8'h03) ? SPC_RESP_SLVERR
                    : SPC_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel, one cycle after the address
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= SPC_RESP_OKAY;
            seen_q <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= SPC_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            unique case (s_axi_araddr[7:2])
                SPC_OFS_CTRL[7:2]: s_axi_rdata[7:0] <= ctrl_q;
                SPC_OFS_STAT[7:2]: begin
                    s_axi_rdata[7:0] <= stat_q;
                    // Arms the clear of each flag in bits 7..3 seen as one
                    seen_q <= stat_q; // see [RL2] [RL4]
                end
                SPC_OFS_TXBUF[7:2]: s_axi_rdata[7:0] <= tx_buf_q;
                SPC_OFS_RXBUF[7:2]: s_axi_rdata[7:0] <= rx_buf_q;
                SPC_OFS_MODE[7:2]: s_axi_rdata[7:0] <= mode_q;
                SPC_OFS_CARD[7:2]: s_axi_rdata[7:0] <= card_q;
                SPC_OFS_IRQ_STAT[7:2]: s_axi_rdata[3:0] <= irq_stat_q;
                SPC_OFS_IRQ_MASK[7:2]: s_axi_rdata[3:0] <= irq_mask_q;
                default: s_axi_rresp <= SPC_RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Plain software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= SPC_MODE_RST;
            card_q <= 8'h00;
            tx_buf_q <= 8'h00;
            irq_mask_q <= 4'h0;
        end else if (wr_fire && w_strb_q) begin
            if (hit(aw_addr_q, SPC_OFS_MODE)) mode_q <= w_data_q;
            if (hit(aw_addr_q, SPC_OFS_CARD)) card_q <= w_data_q;
            if (hit(aw_addr_q, SPC_OFS_TXBUF)) tx_buf_q <= w_data_q;
            if (hit(aw_addr_q, SPC_OFS_IRQ_MASK)) irq_mask_q <= w_data_q[3:0];
        end
    end

    // Control register; an address frame clears address wake over software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= SPC_CTRL_RST;
        end else begin
            if (wr_fire && w_strb_q && hit(aw_addr_q, SPC_OFS_CTRL)) ctrl_q <= w_data_q;
            if (rx_fin && mp_md && rx_xb) ctrl_q.addr_wake_en <= 1'b0; // see [RL12]
        end
    end

    // Transmitter
    assign tx_xb_en = mode_q[SPC_MODE_MP] || mode_q[SPC_MODE_PAR_EN];
    assign tx_xb = mode_q[SPC_MODE_MP] ? stat_q.addr_bit_tx
        : (^tx_buf_q) ^ mode_q[SPC_MODE_PAR_ODD];
    assign tx_end = tx_st_q == TX_SHIFT && tick16 && tx_ph_q == SPC_PH_LAST && tx_bits_q == 4'h1;
    assign tx_start = normal && ctrl_q.tx_on_bit && !stat_q.tx_buf_empty_flag && !sync_md
        && (tx_st_q == TX_IDLE || tx_end); // see [RL5]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_st_q <= TX_IDLE;
            tx_frame_q <= 11'h7ff;
            tx_bits_q <= 4'h0;
            tx_ph_q <= 4'h0;
        end else if (tx_start) begin
            tx_st_q <= TX_SHIFT;
            tx_frame_q <= tx_xb_en ? {1'b1, tx_xb, tx_buf_q, 1'b0} : {2'b11, tx_buf_q, 1'b0};
            tx_bits_q <= tx_xb_en ? 4'hb : 4'ha;
            tx_ph_q <= 4'h0;
        end else if (tx_end || !ctrl_q.tx_on_bit) begin
            tx_st_q <= TX_IDLE;
            tx_frame_q <= 11'h7ff;
        end else if (tx_st_q == TX_SHIFT && tick16) begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == SPC_PH_LAST) begin
                tx_frame_q <= {1'b1, tx_frame_q[10:1]};
                tx_bits_q <= tx_bits_q - 4'h1;
            end
        end
    end
    assign txd = tx_frame_q[0];

    // Receiver
    assign rx_nbits = mp_md || mode_q[SPC_MODE_PAR_EN] ? 4'ha : 4'h9;
    assign rx_w = {rxd_s2, rx_sh_q[10:1]};
    assign rx_fin = ctrl_q.rx_on_bit && normal && ((rx_st_q == RX_DATA && tick16
        && rx_ph_q == SPC_PH_LAST && rx_cnt_q == rx_nbits - 4'h1)
        || (rx_st_q == RX_SYNC && sck_rise && rx_cnt_q == SPC_SYNC_BITS - 4'h1));
    assign rx_data = sync_md ? rx_w[10:3] : (rx_nbits == 4'ha ? rx_w[8:1] : rx_w[9:2]);
    assign rx_xb = rx_w[9];
    assign rx_stop_ok = sync_md || rx_w[10];
    assign rx_perr = !sync_md && !mp_md && mode_q[SPC_MODE_PAR_EN]
        && ((^rx_data) ^ mode_q[SPC_MODE_PAR_ODD]) != rx_xb;
    assign rx_skip = mp_md && ctrl_q.addr_wake_en && !rx_xb; // see [RL10]
    assign rx_acc = rx_fin && !rx_skip; // see [RL11]

    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_q.rx_on_bit || !normal || rx_fin) begin
            rx_st_q <= RX_IDLE;
            rx_ph_q <= 4'h0;
            rx_cnt_q <= 4'h0;
        end else begin
            unique case (rx_st_q)
                RX_IDLE: begin
                    rx_ph_q <= 4'h0;
                    rx_cnt_q <= 4'h0;
                    if (sync_md) rx_st_q <= RX_SYNC; // see [RL8]
                    else if (!rxd_s2) rx_st_q <= RX_START; // see [RL8]
                end
                RX_START: if (tick16) begin
                    rx_ph_q <= rx_ph_q + 4'h1;
                    // Glitch shorter than half a bit is not a start
                    if (rx_ph_q == SPC_PH_MID) begin
                        rx_st_q <= rxd_s2 ? RX_IDLE : RX_DATA;
                        rx_ph_q <= 4'h0;
                    end
                end
                RX_DATA: if (tick16) begin
                    rx_ph_q <= rx_ph_q + 4'h1;
                    if (rx_ph_q == SPC_PH_LAST) rx_cnt_q <= rx_cnt_q + 4'h1;
                end
                RX_SYNC: if (sck_rise) rx_cnt_q <= rx_cnt_q + 4'h1;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_sh_q <= 11'h000;
        end else if ((rx_st_q == RX_DATA && tick16 && rx_ph_q == SPC_PH_LAST)
                || (rx_st_q == RX_SYNC && sck_rise)) begin
            rx_sh_q <= rx_w;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_buf_q <= 8'h00;
        end else if (rx_acc && !stat_q.rx_buf_full_flag) begin
            rx_buf_q <= rx_data; // see [RL11]
        end
    end

    // Status flags: hardware set wins over a software clear
    assign clr = st_wr ? (seen_q & ~w_data_q & SPC_STAT_CLR_MASK) : 8'h00;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= SPC_STAT_RST;
        end else begin
            if (clr[7]) stat_q.tx_buf_empty_flag <= 1'b0; // see [RL2]
            if (clr[7]) stat_q.tx_end_flag <= 1'b0;
            if (clr[6]) stat_q.rx_buf_full_flag <= 1'b0; // see [RL4]
            if (clr[5]) stat_q.overrun_err_flag <= 1'b0;
            if (clr[4]) stat_q.framing_err_flag <= 1'b0;
            if (clr[3]) stat_q.parity_err_flag <= 1'b0;
            if (st_wr) stat_q.addr_bit_tx <= w_data_q[0];
            if (tx_start) stat_q.tx_buf_empty_flag <= 1'b1;
            if (tx_start) stat_q.tx_end_flag <= 1'b0;
            else if (tx_end) stat_q.tx_end_flag <= 1'b1;
            if (!ctrl_q.tx_on_bit) stat_q.tx_buf_empty_flag <= 1'b1; // see [RL7]
            // Flags untouched while reception is off
            if (rx_acc) begin // see [RL9] [RL10]
                if (stat_q.rx_buf_full_flag) begin
                    stat_q.overrun_err_flag <= 1'b1;
                end else begin
                    stat_q.rx_buf_full_flag <= 1'b1;
                    if (!rx_stop_ok) stat_q.framing_err_flag <= 1'b1;
                    if (rx_perr) stat_q.parity_err_flag <= 1'b1;
                end
                if (mp_md) stat_q.addr_bit_rx <= rx_xb; // see [RL12]
            end
        end
    end

    // Request lines
    assign tx_empty_irq = normal && ctrl_q.tx_empty_irq_en && stat_q.tx_buf_empty_flag; // see [RL1]
    assign rx_full_irq = normal && ctrl_q.rx_full_irq_en && stat_q.rx_buf_full_flag; // see [RL3]
    assign rx_error_irq = normal && ctrl_q.rx_full_irq_en && (stat_q.overrun_err_flag
        || stat_q.framing_err_flag || stat_q.parity_err_flag); // see [RL3]
    assign tx_done_irq = normal && ctrl_q.tx_done_irq_en && stat_q.tx_end_flag; // see [RL14]

    // Sticky event register, write one to clear
    assign irq_ev = {rx_acc && (stat_q.rx_buf_full_flag || !rx_stop_ok || rx_perr),
        rx_acc, tx_end, tx_start};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 4'h0;
        end else if (wr_fire && w_strb_q && hit(aw_addr_q, SPC_OFS_IRQ_STAT)) begin
            irq_stat_q <= (irq_stat_q & ~w_data_q[3:0]) | irq_ev;
        end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_txe_gate;
        tx_empty_irq |-> ctrl_q.tx_empty_irq_en && stat_q.tx_buf_empty_flag;
    endproperty
    a_txe_gate: assert property (p_txe_gate) else $error("tx empty request without enable"); // see [RL1]

    property p_txe_cancel;
        st_wr && seen_q.tx_buf_empty_flag && !w_data_q[7] && ctrl_q.tx_on_bit
            |=> !tx_empty_irq;
    endproperty
    a_txe_cancel: assert property (p_txe_cancel) else $error("tx empty request not withdrawn"); // see [RL2]

    property p_rx_gate;
        (rx_full_irq || rx_error_irq) |-> ctrl_q.rx_full_irq_en;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx request without enable"); // see [RL3]

    property p_rx_cancel;
        wr_fire && w_strb_q && hit(aw_addr_q, SPC_OFS_CTRL) && !w_data_q[6]
            |=> !rx_full_irq && !rx_error_irq;
    endproperty
    a_rx_cancel: assert property (p_rx_cancel) else $error("rx request not withdrawn"); // see [RL4]

    property p_tx_start;
        tx_start |=> !txd && stat_q.tx_buf_empty_flag ##1 !txd;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("frame start bit missing"); // see [RL5]

    property p_tx_buf_empty_flag_held;
        !ctrl_q.tx_on_bit |=> stat_q.tx_buf_empty_flag;
    endproperty
    a_tx_buf_empty_flag_held: assert property (p_tx_buf_empty_flag_held) else $error("empty flag not held at one"); // see [RL7]

    property p_rx_begin;
        rx_st_q == RX_IDLE && ctrl_q.rx_on_bit && normal && !sync_md && !rxd_s2
            |=> rx_st_q == RX_START;
    endproperty
    a_rx_begin: assert property (p_rx_begin) else $error("start bit not detected"); // see [RL8]

    property p_rx_off_keep;
        !ctrl_q.rx_on_bit && !st_wr |=> $stable(stat_q[6:3]);
    endproperty
    a_rx_off_keep: assert property (p_rx_off_keep) else $error("rx flags changed while off"); // see [RL9]

    property p_skip;
        rx_fin && rx_skip && !st_wr |=> $stable(rx_buf_q) && $stable(stat_q[6:3]);
    endproperty
    a_skip: assert property (p_skip) else $error("skipped frame touched state"); // see [RL10] [RL11]

    property p_addr_wake;
        rx_fin && mp_md && rx_xb |=> stat_q.addr_bit_rx && !ctrl_q.addr_wake_en;
    endproperty
    a_addr_wake: assert property (p_addr_wake) else $error("address frame not taken"); // see [RL12]

    property p_tend_gate;
        tx_done_irq |-> ctrl_q.tx_done_irq_en && normal;
    endproperty
    a_tend_gate: assert property (p_tend_gate) else $error("tx end request without enable"); // see [RL14] [RL13]

    c_tx_frame: cover property (tx_start ##[1:300] tx_end);
    c_rx_accept: cover property (rx_acc && !stat_q.rx_buf_full_flag);
    c_rx_skip: cover property (rx_fin && rx_skip);
    c_overrun: cover property (rx_acc && stat_q.rx_buf_full_flag);
endmodule // spc_serial_port_control
`default_nettype wire

// ### verif/spc_remote_station.sv
`timescale 1ns/10ps
`default_nettype none
module spc_remote_station (
    // Line side
    output var logic rxd,
    output var logic sck_i,
    input wire logic txd
);
    logic [7:0] got;
    int got_n;
    // External 16x clock runs free
    initial begin
        sck_i = 1'b0;
        forever #40 sck_i = ~sck_i;
    end
    initial rxd = 1'b1;
    // Sixteen clock rises a bit; line idles high
    task automatic send(input logic [7:0] d, input logic use_xb, input logic xb);
        logic [10:0] f;
        f = use_xb ? {1'b1, xb, d, 1'b0} : {2'b11, d, 1'b0};
        for (int i = 0; i < (use_xb ? 11 : 10); i++) begin
            rxd <= f[i];
            repeat (16) @(posedge sck_i);
        end
    endtask
    // Mid-bit sampling from the start edge
    initial begin
        got_n = 0;
        forever begin
            @(negedge txd);
            repeat (8) @(posedge sck_i);
            for (int i = 0; i < 8; i++) begin
                repeat (16) @(posedge sck_i);
                got[i] = txd;
            end
            repeat (16) @(posedge sck_i);
            got_n++;
        end
    end
endmodule // spc_remote_station
`default_nettype wire

// ### verif/serial_port_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module serial_port_control_test;
    import spc_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, rxd, txd, sck_i, sck_o, sck_oe;
    logic tx_empty_irq, rx_full_irq, rx_error_irq, tx_done_irq, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int miscompares, compares;
    spc_serial_port_control #(.TICK_DIV(4)) i_spc_serial_port_control (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxd(rxd),
        .txd(txd), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
        .tx_empty_irq(tx_empty_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq),
        .tx_done_irq(tx_done_irq), .irq(irq));
    spc_remote_station i_spc_remote_station (.rxd(rxd), .sck_i(sck_i), .txd(txd));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic expire(input int n);
        if (n >= 5000) begin
            miscompares++;
            $display("BAD wait expected done seen timeout");
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 5000);
        expire(n);
        chk("bresp", 32'h0, {30'h0, bresp});
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 5000);
        rd = rdata;
        expire(n);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    task automatic t_reset;
        rd_reg(SPC_OFS_CTRL, SPC_RESP_OKAY);
        chk("ctrl reset", 32'h00, rd);
        rd_reg(SPC_OFS_STAT, SPC_RESP_OKAY);
        chk("stat reset", 32'h84, rd);
        rd_reg(8'h20, SPC_RESP_SLVERR);
        chk("unmapped", 32'h0, rd);
        $display("reset test done");
    endtask
    task automatic t_tx;
        int n;
        wr(SPC_OFS_CTRL, 8'h86);
        chk("txe irq on", 32'h1, {31'h0, tx_empty_irq});
        chk("tend irq", 32'h1, {31'h0, tx_done_irq});
        wr(SPC_OFS_CTRL, 8'h22);
        chk("txe irq off", 32'h0, {31'h0, tx_empty_irq});
        wr(SPC_OFS_TXBUF, 8'h5a);
        rd_reg(SPC_OFS_STAT, SPC_RESP_OKAY);
        wr(SPC_OFS_STAT, 8'h7e);
        for (n = 0; n < 5000 && i_spc_remote_station.got_n == 0; n++) @(posedge aclk);
        expire(n);
        chk("tx byte", 32'h5a, {24'h0, i_spc_remote_station.got});
        wr(SPC_OFS_TXBUF, 8'ha5);
        rd_reg(SPC_OFS_STAT, SPC_RESP_OKAY);
        wr(SPC_OFS_STAT, 8'h7e);
        // Land inside the start bit, then abort the frame
        repeat (200) @(posedge aclk);
        chk("start bit", 32'h0, {31'h0, txd});
        wr(SPC_OFS_CTRL, 8'h01);
        chk("sck oe", 32'h1, {31'h0, sck_oe});
        rd = {31'h0, sck_o};
        repeat (32) @(posedge aclk);
        chk("sck", rd ^ 32'h1, {31'h0, sck_o});
        chk("txd idle", 32'h1, {31'h0, txd});
        rd_reg(SPC_OFS_STAT, SPC_RESP_OKAY);
        wr(SPC_OFS_STAT, 8'h7e);
        rd_reg(SPC_OFS_STAT, SPC_RESP_OKAY);
        chk("txe held", 32'h80, rd & 32'h80);
        $display("transmit test done");
    endtask
    task automatic t_rx;
        int n;
        wr(SPC_OFS_MODE, 8'h01);
        wr(SPC_OFS_IRQ_MASK, 8'h04);
        wr(SPC_OFS_CTRL, 8'h52);
        i_spc_remote_station.send(8'hc3, 1'b1, 1'b1);
        for (n = 0; n < 5000 && rx_full_irq !== 1'b1; n++) @(posedge aclk);
        expire(n);
        chk("irq line", 32'h1, {31'h0, irq});
        chk("rx err irq", 32'h1, {31'h0, rx_error_irq});
        rd_reg(SPC_OFS_RXBUF, SPC_RESP_OKAY);
        chk("rx byte", 32'hc3, rd);
        wr(SPC_OFS_CTRL, 8'h02);
        chk("rx irq off", 32'h0, {31'h0, rx_full_irq});
        wr(SPC_OFS_CTRL, 8'h42);
        chk("rx irq back", 32'h1, {31'h0, rx_full_irq});
        rd_reg(SPC_OFS_STAT, SPC_RESP_OKAY);
        chk("rx full kept", 32'h40, rd & 32'h40);
        wr(SPC_OFS_STAT, 8'hb6);
        chk("rx irq clear", 32'h0, {31'h0, rx_full_irq});
        chk("rx err clear", 32'h0, {31'h0, rx_error_irq});
        wr(SPC_OFS_IRQ_STAT, 8'h04);
        chk("irq cleared", 32'h0, {31'h0, irq});
        $display("receive test done");
    endtask
    task automatic t_mp;
        int n;
        wr(SPC_OFS_MODE, 8'h04);
        wr(SPC_OFS_CTRL, 8'h5a);
        i_spc_remote_station.send(8'h11, 1'b1, 1'b0);
        repeat (40) @(posedge aclk);
        rd_reg(SPC_OFS_STAT, SPC_RESP_OKAY);
        chk("skip flags", 32'h0, rd & 32'h70);
        rd_reg(SPC_OFS_RXBUF, SPC_RESP_OKAY);
        chk("skip buf", 32'hc3, rd);
        i_spc_remote_station.send(8'h22, 1'b1, 1'b1);
        for (n = 0; n < 5000 && rx_full_irq !== 1'b1; n++) @(posedge aclk);
        expire(n);
        rd_reg(SPC_OFS_STAT, SPC_RESP_OKAY);
        chk("addr flags", 32'h42, rd & 32'h42);
        rd_reg(SPC_OFS_CTRL, SPC_RESP_OKAY);
        chk("wake cleared", 32'h52, rd);
        rd_reg(SPC_OFS_RXBUF, SPC_RESP_OKAY);
        chk("addr byte", 32'h22, rd);
        wr(SPC_OFS_CARD, 8'h01);
        chk("card gate", 32'h0, {31'h0, rx_full_irq});
        $display("address wake test done");
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_tx();
        t_rx();
        t_mp();
        conclude();
    end
    initial begin
        #400000;
        miscompares++;
        $display("BAD run expected end seen timeout");
        conclude();
    end
endmodule // serial_port_control_test
`default_nettype wire
